/* verilog/addr_map_consts.svh */
// Constants of the address map and the external bus unit
// Assumes inclusion by the bus unit, the checker and the bench
`ifndef ADDR_MAP_CONSTS_SVH
`define ADDR_MAP_CONSTS_SVH
`define SEG_BITS          8
`define PAGE_BIT_HI       15
`define PAGE_BIT_LO       14
`define SYS_LO            24'h008000
`define SYS_HI            24'h00ffff
`define CREG_LO           24'h00fc00
`define CREG_HI           24'h00ffff
`define CREG_BYTES        1024
`define CREG_AREA_BYTES   512
`define DUAL_LO           24'h00f400
`define DUAL_HI           24'h00fbff
`define DUAL_BIT_LO       24'h00fb00
`define EXT0_LO           24'h000000
`define EXT0_HI           24'h007fff
`define EXT1_LO           24'h010000
`define EXT1_HI           24'h1fffff
`define LOCAL_LO          24'h200000
`define LOCAL_HI          24'h2007ff
`define EXTIO_LO          24'h200800
`define EXTIO_HI          24'h3fffff
`define EXT2_LO           24'h400000
`define EXT2_HI           24'hbeffff
`define PROG_LO           24'hc00000
`define PROG_HI           24'hf7ffff
`define RSV_LO            24'hf80000
`define RSV_HI            24'hffefff
`define FREG_LO           24'hfff000
`define FREG_HI           24'hffffff
`define FREG_DEFINED_TOP  12'h0ff
`define TRAP_CODE         16'h9b9b
`define WIN_COUNT         5
`define CS_COUNT          4
`define SEGLINE_MAX       8
`define TIMING_RESET      8'h01
`endif

/* verilog/addr_map_pkg.sv */
// Types shared by the address map and the external bus unit
// Assumes the constants header is on the include path
package addr_map_pkg;
  typedef enum logic [2:0] {
    MODE_SINGLE   = 3'h0,
    MODE_D16_DMUX = 3'h1,
    MODE_D16_MUX  = 3'h2,
    MODE_D8_MUX   = 3'h3,
    MODE_D8_DMUX  = 3'h4
  } bus_mode_t;
  typedef enum logic [3:0] {
    REG_EXT, REG_SYS, REG_CREG, REG_LOCAL, REG_EXTIO, REG_PROG, REG_RSV, REG_FREG
  } region_t;
  typedef struct packed {
    logic [23:0] base;
    logic [4:0]  size_log2;
    logic        enable;
  } window_range_t;
  typedef struct packed {
    bus_mode_t   mode;
    logic [7:0]  wait_cycles;
  } window_setting_t;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        word;
    logic [23:0] addr;
    logic [15:0] wdata;
  } access_req_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_WAIT = 3'b011,
    ST_DATA = 3'b010,
    ST_DONE = 3'b110
  } bus_state_t;
endpackage

/* verilog/window_match.sv */
// One address window comparator
// Assumes a combinational use inside the bus unit
`timescale 1ns/10ps
module window_match
  import addr_map_pkg::*;
(
  input  wire window_range_t range_in,
  input  wire logic [23:0]   addr_in,
  output logic               hit_out
);
  logic [23:0] mask;
  always_comb begin
    mask    = 24'hffffff << range_in.size_log2;
    hit_out = range_in.enable && ((addr_in & mask) == (range_in.base & mask));
  end
endmodule // window_match

/* verilog/address_map_external_bus_ctrl.sv */
// Address map decoder and external bus unit
`timescale 1ns/10ps
`include "addr_map_consts.svh"
module address_map_external_bus_ctrl
  import addr_map_pkg::*;
(
  input  wire logic                 clk_sys_in,
  input  wire logic                 resetn_in,
  input  wire access_req_t          req_in,
  input  wire logic                 req_fetch_in,
  input  wire logic [15:0]          internal_rdata_in,
  input  wire bus_mode_t            global_mode_in,
  input  wire logic [3:0]           segment_lines_in,
  input  wire window_range_t [4:1]  window_range_setting_in,
  input  wire window_setting_t [4:0] window_setting_in,
  input  wire logic [15:0]          data_port_in,
  output logic                      req_ready_out,
  output logic                      done_out,
  output logic [15:0]               rdata_out,
  output logic                      access_trap_out,
  output logic                      internal_sel_out,
  output logic                      pipeline_off_out,
  output logic                      bit_addressable_out,
  output logic                      control_area_out,
  output logic [`SEG_BITS-1:0]      segment_out,
  output logic [1:0]                page_out,
  output logic                      reference_clock_output_out,
  output logic [15:0]               address_port_out,
  output logic [15:0]               data_port_out,
  output logic [15:0]               data_port_oe_out,
  output logic [7:0]                segment_port_out,
  output logic                      ale_out,
  output logic                      rd_n_out,
  output logic                      wr_n_out,
  output logic [`CS_COUNT-1:0]      cs_n_out,
  output logic                      cs4_internal_out,
  output logic                      local_bus_sel_out
);
  typedef struct packed {
    bus_state_t      st;
    access_req_t     acc;
    window_setting_t set;
    logic [2:0]      win;
    logic [7:0]      wcnt;
    logic            ready;
    logic            done;
    logic [15:0]     rdata;
    logic            trap;
    logic            intsel;
    logic            pipe_off;
    logic            bitad;
    logic            creg;
    logic [7:0]      seg;
    logic [1:0]      page;
    logic            refclk;
    logic [15:0]     aport;
    logic [15:0]     dport;
    logic [15:0]     doe;
    logic [7:0]      segport;
    logic            ale;
    logic            rd_n;
    logic            wr_n;
    logic [3:0]      cs_n;
    logic            cs4;
    logic            lbus;
  } state_t;

  state_t      s_q;
  state_t      s_d;
  logic [4:1]  hit;
  region_t     region;
  logic [2:0]  win_sel;
  logic [7:0]  seg_mask;
  logic        is_mux;
  logic        is_d8;

  genvar gi;
  generate
    for (gi = 1; gi <= 4; gi++) begin : g_win
      window_match u_match (
        .range_in (window_range_setting_in[gi]),
        .addr_in  (req_in.addr),
        .hit_out  (hit[gi])
      );
    end
  endgenerate

  always_comb begin
    region = REG_EXT;
    if (req_in.addr >= `SYS_LO && req_in.addr <= `SYS_HI) begin
      region = REG_SYS;
    end
    if (req_in.addr >= `CREG_LO && req_in.addr <= `CREG_HI) begin
      region = REG_CREG;
    end
    if (req_in.addr >= `LOCAL_LO && req_in.addr <= `LOCAL_HI) begin
      region = REG_LOCAL;
    end
    if (req_in.addr >= `EXTIO_LO && req_in.addr <= `EXTIO_HI) begin
      region = REG_EXTIO;
    end
    if (req_in.addr >= `PROG_LO && req_in.addr <= `PROG_HI) begin
      region = REG_PROG;
    end
    if (req_in.addr > `EXT2_HI && req_in.addr < `PROG_LO) begin
      region = REG_RSV;
    end
    if (req_in.addr >= `RSV_LO && req_in.addr <= `RSV_HI) begin
      region = REG_RSV;
    end
    if (req_in.addr >= `FREG_LO) begin
      region = REG_FREG;
    end
    if (hit[4]) begin
      win_sel = 3'h4;
    end else if (hit[3]) begin
      win_sel = 3'h3;
    end else if (hit[2]) begin
      win_sel = 3'h2;
    end else if (hit[1]) begin
      win_sel = 3'h1;
    end else begin
      win_sel = 3'h0;
    end
    seg_mask = 8'hff >> (4'h8 - ((segment_lines_in > 4'h8) ? 4'h8 : segment_lines_in));
    is_mux   = (s_q.set.mode == MODE_D16_MUX) || (s_q.set.mode == MODE_D8_MUX);
    is_d8    = (s_q.set.mode == MODE_D8_MUX) || (s_q.set.mode == MODE_D8_DMUX);

    s_d        = s_q;
    s_d.done   = 1'b0;
    s_d.trap   = 1'b0;
    // reference clock toggles on every clk_sys_in rise, bus phases change on both its edges
    s_d.refclk = ~s_q.refclk;
    unique case (s_q.st)
      ST_IDLE: begin
        s_d.ready = 1'b1;
        if (req_in.valid && s_q.ready) begin
          s_d.ready    = 1'b0;
          s_d.acc      = req_in;
          s_d.seg      = req_in.addr[23:16];
          s_d.page     = req_in.addr[`PAGE_BIT_HI:`PAGE_BIT_LO];
          s_d.pipe_off = (region == REG_EXTIO);
          s_d.creg     = (region == REG_CREG);
          // bit addressable upper dual RAM and registers
          s_d.bitad    = (req_in.addr >= `DUAL_BIT_LO && req_in.addr <= `DUAL_HI) || (region == REG_CREG);
          s_d.acc.word = req_in.word & ~req_in.addr[0];
          if (region == REG_RSV) begin
            s_d.trap = 1'b1;
            s_d.done = 1'b1;
            s_d.st   = ST_DONE;
          end else if (region == REG_FREG) begin
            s_d.rdata  = (req_in.addr[11:0] > `FREG_DEFINED_TOP) ? `TRAP_CODE : internal_rdata_in;
            s_d.intsel = 1'b1;
            s_d.done   = 1'b1;
            s_d.st     = ST_DONE;
          end else if (region == REG_SYS || region == REG_CREG || region == REG_PROG) begin
            s_d.rdata  = internal_rdata_in;
            s_d.intsel = 1'b1;
            s_d.done   = 1'b1;
            s_d.st     = ST_DONE;
          end else if (global_mode_in == MODE_SINGLE && region != REG_LOCAL) begin
            // no external cycle in single chip
            s_d.trap = 1'b1;
            s_d.done = 1'b1;
            s_d.st   = ST_DONE;
          end else begin
            s_d.win  = (region == REG_LOCAL) ? 3'h0 : win_sel;
            s_d.set  = window_setting_in[(region == REG_LOCAL) ? 3'h0 : win_sel];
            if (s_d.set.mode == MODE_SINGLE) begin
              s_d.set.mode = global_mode_in;
            end
            s_d.lbus    = (region == REG_LOCAL);
            s_d.segport = req_in.addr[23:16] & seg_mask;
            s_d.st      = ST_ADDR;
          end
        end
      end
      ST_ADDR: begin
        s_d.aport = s_q.acc.addr[15:0];
        s_d.ale   = 1'b1;
        if (is_mux) begin
          s_d.dport = s_q.acc.addr[15:0];
          s_d.doe   = 16'hffff;
        end
        if (!s_q.lbus && s_q.win != 3'h4) begin
          s_d.cs_n = ~(4'h1 << s_q.win[1:0]);
        end
        s_d.cs4  = !s_q.lbus && (s_q.win == 3'h4);
        s_d.wcnt = s_q.set.wait_cycles;
        s_d.st   = ST_WAIT;
      end
      ST_WAIT: begin
        s_d.ale  = 1'b0;
        s_d.rd_n = s_q.acc.write;
        s_d.wr_n = ~s_q.acc.write;
        // data on full or low byte
        s_d.dport = s_q.acc.wdata;
        s_d.doe   = s_q.acc.write ? (is_d8 ? 16'h00ff : 16'hffff) : 16'h0000;
        if (s_q.wcnt == 8'h00) begin
          s_d.st = ST_DATA;
        end else begin
          s_d.wcnt = s_q.wcnt - 8'h01;
        end
      end
      ST_DATA: begin
        s_d.rdata = is_d8 ? {8'h00, data_port_in[7:0]} : data_port_in;
        s_d.rd_n  = 1'b1;
        s_d.wr_n  = 1'b1;
        s_d.doe   = 16'h0000;
        s_d.cs_n  = 4'hf;
        s_d.cs4   = 1'b0;
        s_d.done  = 1'b1;
        s_d.st    = ST_DONE;
      end
      ST_DONE: begin
        s_d.intsel = 1'b0;
        s_d.lbus   = 1'b0;
        s_d.ready  = 1'b1;
        s_d.st     = ST_IDLE;
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_q      <= '0;
      s_q.rd_n <= 1'b1;
      s_q.wr_n <= 1'b1;
      s_q.cs_n <= 4'hf;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    req_ready_out              = s_q.ready;
    done_out                   = s_q.done;
    rdata_out                  = s_q.rdata;
    access_trap_out            = s_q.trap;
    internal_sel_out           = s_q.intsel;
    pipeline_off_out           = s_q.pipe_off;
    bit_addressable_out        = s_q.bitad;
    control_area_out           = s_q.creg;
    segment_out                = s_q.seg;
    page_out                   = s_q.page;
    reference_clock_output_out = s_q.refclk;
    address_port_out           = s_q.aport;
    data_port_out              = s_q.dport;
    data_port_oe_out           = s_q.doe;
    segment_port_out           = s_q.segport;
    ale_out                    = s_q.ale;
    rd_n_out                   = s_q.rd_n;
    wr_n_out                   = s_q.wr_n;
    cs_n_out                   = s_q.cs_n;
    cs4_internal_out           = s_q.cs4;
    local_bus_sel_out          = s_q.lbus;
  end
endmodule // address_map_external_bus_ctrl

/* verification/ebus_properties.sv */
// Checker for the address map and bus unit
// Bound to the bus unit top, sees its ports only
`timescale 1ns/10ps
`include "addr_map_consts.svh"
module ebus_properties
  import addr_map_pkg::*;
(
  input wire logic        clk_sys_in,
  input wire logic        resetn_in,
  input wire access_req_t req_in,
  input wire bus_mode_t   global_mode_in,
  input wire logic        req_ready_out,
  input wire logic        done_out,
  input wire logic        access_trap_out,
  input wire logic        pipeline_off_out,
  input wire logic        reference_clock_output_out,
  input wire logic        ale_out,
  input wire logic        rd_n_out,
  input wire logic        wr_n_out,
  input wire logic [3:0]  cs_n_out,
  input wire logic        cs4_internal_out,
  input wire logic        local_bus_sel_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  logic take;
  assign take = req_ready_out && req_in.valid;
  a_trap_with_done: assert property (access_trap_out |-> done_out)
    else $error("trap without done");
  a_done_then_ready: assert property (done_out |=> !done_out && req_ready_out)
    else $error("done not followed by ready");
  a_one_select: assert property ($onehot0(~cs_n_out))
    else $error("several selects active");
  a_strobe_exclusive: assert property (!(!rd_n_out && !wr_n_out))
    else $error("read and write strobes together");
  a_refclk_toggles: assert property (1'b1 |=> reference_clock_output_out != $past(reference_clock_output_out))
    else $error("reference clock stalled");
  a_ale_then_strobe: assert property ($rose(ale_out) |=> !rd_n_out || !wr_n_out)
    else $error("no strobe after address phase");
  a_single_quiet: assert property (global_mode_in == MODE_SINGLE && !local_bus_sel_out
    |-> cs_n_out == 4'hf && !ale_out)
    else $error("bus activity in single chip mode");
  a_cs4_no_pin: assert property (cs4_internal_out |-> cs_n_out == 4'hf)
    else $error("window 4 select on a pin");
  a_extio_pipe_off: assert property (take && req_in.addr >= `EXTIO_LO && req_in.addr <= `EXTIO_HI
    |=> pipeline_off_out)
    else $error("pipeline not off in io area");
  a_reserved_trap: assert property (take && req_in.addr >= `RSV_LO && req_in.addr <= `RSV_HI
    |-> ##[1:2] (done_out && access_trap_out))
    else $error("reserved access without trap");
endmodule // ebus_properties
bind address_map_external_bus_ctrl ebus_properties ebus_properties_inst (.clk_sys_in, .resetn_in,
  .req_in, .global_mode_in, .req_ready_out, .done_out, .access_trap_out, .pipeline_off_out,
  .reference_clock_output_out, .ale_out, .rd_n_out, .wr_n_out, .cs_n_out, .cs4_internal_out,
  .local_bus_sel_out);

/* verification/ext_mem_model.sv */
// Memory on the far side of the external bus
// Sees strobes and data lines of the bus unit
`timescale 1ns/10ps
module ext_mem_model (
  input  wire logic        clk_sys_in,
  input  wire logic        rd_n_in,
  input  wire logic        wr_n_in,
  input  wire logic [15:0] bus_in,
  input  wire logic [15:0] bus_oe_in,
  output logic      [15:0] bus_out,
  output logic      [15:0] wdata_out
);
  localparam logic [15:0] RESP = 16'h5ac3;
  logic [15:0] drv_q = 16'h0000;
  // Released bus shows the inverse of its last value
  always_ff @(posedge clk_sys_in) begin
    drv_q <= ~bus_out;
    if (!wr_n_in && |bus_oe_in) wdata_out <= bus_in;
  end
  // data driven while read strobe low
  assign bus_out = !rd_n_in ? RESP : drv_q;
endmodule // ext_mem_model

/* verification/tb_top.sv */
// Bench for the address map and bus unit
// Memory model answers external cycles
`timescale 1ns/10ps
`include "addr_map_consts.svh"
module tb_top
  import addr_map_pkg::*;
;
  logic clk_sys_in = 1'b0, resetn_in, req_fetch_in, req_ready_out, done_out, access_trap_out;
  logic pipeline_off_out, bit_addressable_out, control_area_out, rd_n_out, wr_n_out, cs4_internal_out;
  logic ale_out, internal_sel_out, local_bus_sel_out, is_seen, lb_seen;
  logic [15:0] address_port_out, ap_seen, dp_addr, oe_addr, oe_wr;
  access_req_t           req_in;
  bus_mode_t             global_mode_in;
  logic [3:0]            segment_lines_in;
  window_range_t [4:1]   window_range_setting_in;
  window_setting_t [4:0] window_setting_in;
  logic [15:0]           internal_rdata_in, data_port_in, data_port_out, data_port_oe_out, rdata_out, wlast;
  logic [7:0]            segment_out, segment_port_out, seg_seen;
  logic [1:0]            page_out;
  logic [3:0]            cs_n_out, cs_seen;
  logic                  cs4_seen, trap_q;
  int                    cyc, c0, fails = 0, samples_checked = 0;

  always #5 clk_sys_in = ~clk_sys_in;

  address_map_external_bus_ctrl address_map_external_bus_ctrl_inst (
    .clk_sys_in, .resetn_in, .req_in, .req_fetch_in, .internal_rdata_in, .global_mode_in,
    .segment_lines_in, .window_range_setting_in, .window_setting_in, .data_port_in,
    .req_ready_out, .done_out, .rdata_out, .access_trap_out, .internal_sel_out,
    .pipeline_off_out, .bit_addressable_out, .control_area_out, .segment_out, .page_out,
    .reference_clock_output_out(), .address_port_out, .data_port_out, .data_port_oe_out,
    .segment_port_out, .ale_out, .rd_n_out, .wr_n_out, .cs_n_out, .cs4_internal_out,
    .local_bus_sel_out);
  ext_mem_model ext_mem_model_inst (.clk_sys_in, .rd_n_in(rd_n_out), .wr_n_in(wr_n_out),
    .bus_in(data_port_out), .bus_oe_in(data_port_oe_out), .bus_out(data_port_in), .wdata_out(wlast));

  task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One byte access, held until taken, then waits for done
  task automatic access(input logic [23:0] a, input logic w, input logic [15:0] wd);
    @(posedge clk_sys_in);
    req_in <= '{1'b1, w, 1'b0, a, wd};
    do @(negedge clk_sys_in); while (req_ready_out !== 1'b1);
    @(posedge clk_sys_in);
    req_in.valid <= 1'b0;
    cyc = 0;
    cs_seen = 4'hf;
    cs4_seen = 1'b0;
    seg_seen = 8'h00;
    is_seen = 1'b0;
    lb_seen = 1'b0;
    ap_seen = 16'h0000;
    dp_addr = 16'h0000;
    oe_addr = 16'h0000;
    oe_wr = 16'h0000;
    #1;
    forever begin
      cs_seen &= cs_n_out;
      cs4_seen |= cs4_internal_out;
      seg_seen |= segment_port_out;
      is_seen |= internal_sel_out;
      lb_seen |= local_bus_sel_out;
      if (ale_out === 1'b1) begin
        ap_seen = address_port_out;
        dp_addr = data_port_out;
        oe_addr = data_port_oe_out;
      end
      if (wr_n_out === 1'b0) oe_wr = data_port_oe_out;
      if (done_out === 1'b1 || cyc >= 400) break;
      @(posedge clk_sys_in);
      #1;
      cyc++;
    end
    if (done_out !== 1'b1) fails++;
    trap_q = access_trap_out;
  endtask

  task automatic t_map;
    access(24'hf80010, 1'b0, 16'h0000);
    check("rsv_trap", trap_q, 1'b1);
    access(24'hfff800, 1'b0, 16'h0000);
    check("freg_code", rdata_out, `TRAP_CODE);
    access(24'h00fb10, 1'b0, 16'h0000);
    check("bit_area", bit_addressable_out, 1'b1);
    check("dual_not_ctrl", control_area_out, 1'b0);
    access(24'h00fd10, 1'b1, 16'h0000);
    check("ctrl_area", control_area_out, 1'b1);
    check("ctrl_bits", bit_addressable_out, 1'b1);
    check("ctrl_wr_ok", trap_q, 1'b0);
    access(24'h00f700, 1'b0, 16'h0000);
    check("int_data", rdata_out, 16'h1e2d);
    check("int_sel", is_seen, 1'b1);
    check("not_bit", bit_addressable_out, 1'b0);
    check("not_ctrl", control_area_out, 1'b0);
    check("sys_seg", segment_out, 8'h00);
    access(24'h12c456, 1'b0, 16'h0000);
    check("segment", segment_out, 8'h12);
    check("page", page_out, 2'h3);
    access(24'h250000, 1'b0, 16'h0000);
    check("io_pipe", pipeline_off_out, 1'b1);
    access(24'h450000, 1'b0, 16'h0000);
    check("mem_pipe", pipeline_off_out, 1'b0);
    check("ext_sel", cs_seen, 4'he);
    check("ext_not_int", is_seen, 1'b0);
    access(24'h200010, 1'b0, 16'h0000);
    check("local_ok", trap_q, 1'b0);
    check("local_sel", lb_seen, 1'b1);
    check("local_no_cs", cs_seen, 4'hf);
    $display("test map done");
  endtask

  task automatic t_windows;
    @(posedge clk_sys_in);
    window_range_setting_in <= {{24'h480000, 5'd8, 1'b1}, {24'h480000, 5'd12, 1'b1},
                                {24'h400000, 5'd12, 1'b1}, {24'h400000, 5'd16, 1'b1}};
    access(24'h400100, 1'b0, 16'h0000);
    check("win2_over_1", cs_seen, 4'hb);
    access(24'h408000, 1'b0, 16'h0000);
    check("win1", cs_seen, 4'hd);
    access(24'h500000, 1'b0, 16'h0000);
    check("default", cs_seen, 4'he);
    access(24'h480010, 1'b0, 16'h0000);
    check("win4_int", cs4_seen, 1'b1);
    check("win4_pins", cs_seen, 4'hf);
    access(24'h480200, 1'b0, 16'h0000);
    check("win3_no4", cs4_seen, 1'b0);
    check("win3_pin", cs_seen, 4'h7);
    $display("test windows done");
  endtask

  task automatic t_modes;
    bus_mode_t ml [4] = '{MODE_D16_DMUX, MODE_D16_MUX, MODE_D8_MUX, MODE_D8_DMUX};
    logic d8;
    foreach (ml[i]) begin
      @(posedge clk_sys_in);
      global_mode_in <= ml[i];
      d8 = (ml[i] == MODE_D8_MUX) || (ml[i] == MODE_D8_DMUX);
      access(24'h45a5c4, 1'b1, 16'h0077);
      check("wr_byte", wlast[7:0], 8'h77);
      check("wr_lanes", oe_wr, d8 ? 16'h00ff : 16'hffff);
      access(24'h45a5c4, 1'b0, 16'h0000);
      check("rd_data", rdata_out, d8 ? 16'h00c3 : 16'h5ac3);
      check("seg_full", seg_seen, 8'h45);
      if (ml[i] == MODE_D16_MUX || ml[i] == MODE_D8_MUX) begin
        check("mux_addr", dp_addr, 16'ha5c4);
        check("mux_oe", oe_addr, 16'hffff);
      end else begin
        check("dmux_addr", ap_seen, 16'ha5c4);
      end
    end
    @(posedge clk_sys_in);
    segment_lines_in <= 4'h4;
    access(24'h45a5c4, 1'b0, 16'h0000);
    check("seg_cut", seg_seen, 8'h05);
    $display("test modes done");
  endtask

  task automatic t_wait_single;
    access(24'h500000, 1'b0, 16'h0000);
    c0 = cyc;
    @(posedge clk_sys_in);
    window_setting_in[0].wait_cycles <= 8'h03;
    access(24'h500000, 1'b0, 16'h0000);
    check("wait_len", cyc - c0, 3);
    @(posedge clk_sys_in);
    window_setting_in[1].mode <= MODE_D16_MUX;
    access(24'h408000, 1'b0, 16'h0000);
    check("win_mux", dp_addr, 16'h8000);
    check("win_rd16", rdata_out, 16'h5ac3);
    access(24'h500000, 1'b0, 16'h0000);
    check("dflt_rd8", rdata_out, 16'h00c3);
    @(posedge clk_sys_in);
    global_mode_in <= MODE_SINGLE;
    access(24'h450000, 1'b0, 16'h0000);
    check("single_trap", trap_q, 1'b1);
    check("single_cs", cs_seen, 4'hf);
    $display("test wait and single done");
  endtask

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    resetn_in <= 1'b0;
    req_in <= '0;
    req_fetch_in <= 1'b0;
    internal_rdata_in <= 16'h1e2d;
    global_mode_in <= MODE_D16_DMUX;
    segment_lines_in <= 4'h8;
    window_range_setting_in <= '0;
    window_setting_in <= '0;
    repeat (20) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    t_map();
    t_windows();
    t_modes();
    t_wait_single();
    report_and_stop();
  end

  initial begin
    #200us;
    fails++;
    report_and_stop();
  end
endmodule // tb_top
